// >>> design/power_managed_clock_switch.sv
module power_managed_clock_switch
  import clock_switch_pkg::*;
#(
  parameter int unsigned FAST_STABLE_COUNT = FAST_STABLE_CYCLES
) (
  input  wire logic          sys_clk,
  input  wire logic          reset_n,
  input  wire logic          select_write,
  input  wire logic [1:0]    select_write_data,
  input  wire logic [2:0]    internal_freq_select,
  input  wire logic          secondary_osc_enable,
  input  wire primary_cfg_t  primary_osc_config,
  input  wire logic          wake_event,
  input  wire logic          primary_osc_in,
  input  wire logic          slow_internal_rc_in,
  input  wire logic          secondary_crystal_osc_in,
  output source_t            system_clock_source,
  output logic               core_clock_enable,
  output logic               first_quarter_phase_hold,
  output logic               primary_osc_power,
  output logic               secondary_osc_power,
  output logic               watchdog_enable,
  output logic               watchdog_clear,
  output clock_status_t      status
);

  switch_state_t           state_reg, state_next;
  source_t                 active_reg, active_next;
  source_t                 target_reg, target_next;
  source_t                 leaving_reg, leaving_next;
  logic [EDGE_CNT_W-1:0]   edge_cnt_reg, edge_cnt_next;
  logic                    xtal_wait_reg, xtal_wait_next;
  logic                    fast_pending_reg, fast_pending_next;
  logic                    enable_last_reg;
  clock_status_t           status_next;
  logic                    gate_next, hold_next, prim_pwr_next, sec_pwr_next;
  logic                    wdt_en_next, wdt_clr_next;
  logic                    cpu_load, fast_load;
  logic                    cpu_expired, fast_expired;
  logic                    fall_primary_pin, fall_slow_rc, fall_secondary;
  logic                    fall_primary, fall_old, fall_new;
  logic [1:0]              new_select;
  logic                    request;

  function automatic source_t source_of(input logic [1:0] sel);
    unique case (sel)
      SEL_PRIMARY:   source_of = SRC_PRIMARY;
      SEL_SECONDARY: source_of = SRC_SECONDARY;
      default:       source_of = SRC_INTERNAL;
    endcase
  endfunction : source_of

  function automatic logic is_crystal(input primary_cfg_t cfg);
    is_crystal = (cfg == CFG_LOW_POWER_CRYSTAL) || (cfg == CFG_STANDARD_CRYSTAL) ||
                 (cfg == CFG_HIGH_SPEED_CRYSTAL);
  endfunction : is_crystal

  function automatic logic source_fall(input source_t src, input logic f_pri, input logic f_sec,
                                       input logic f_rc);
    unique case (src)
      SRC_PRIMARY:   source_fall = f_pri;
      SRC_SECONDARY: source_fall = f_sec;
      default:       source_fall = f_rc;
    endcase
  endfunction : source_fall

  osc_fall_detect u_primary_fall (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .osc_in     (primary_osc_in),
    .fall_pulse (fall_primary_pin)
  );

  osc_fall_detect u_slow_rc_fall (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .osc_in     (slow_internal_rc_in),
    .fall_pulse (fall_slow_rc)
  );

  osc_fall_detect u_secondary_fall (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .osc_in     (secondary_crystal_osc_in),
    .fall_pulse (fall_secondary)
  );

  cycle_timer #(.WIDTH(CPU_TIMER_W)) u_cpu_timer (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .load       (cpu_load),
    .load_value (CPU_TIMER_W'(CPU_STARTUP_CYCLES)),
    .expired    (cpu_expired)
  );

  cycle_timer #(.WIDTH(FAST_TIMER_W)) u_fast_timer (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .load       (fast_load),
    .load_value (FAST_TIMER_W'(FAST_STABLE_COUNT)),
    .expired    (fast_expired)
  );

  // A primary configured as slow RC is clocked by that oscillator
  assign fall_primary = (primary_osc_config == CFG_SLOW_INTERNAL_RC) ? fall_slow_rc : fall_primary_pin;
  assign fall_old     = source_fall(active_reg, fall_primary, fall_secondary, fall_slow_rc);
  assign fall_new     = source_fall(target_reg, fall_primary, fall_secondary, fall_slow_rc);

  // Reserved 11 is folded onto internal; bit zero cannot stick without the secondary
  always_comb begin
    new_select = status.clock_source_select;
    request    = 1'b0;
    if (select_write) begin
      new_select = select_write_data;
      if (!secondary_osc_enable || select_write_data == 2'h3) begin
        new_select = {select_write_data[1], 1'b0};
      end
    end else if (enable_last_reg && !secondary_osc_enable && active_reg == SRC_SECONDARY) begin
      new_select = {status.clock_source_select[1], 1'b0};
    end
    request = (new_select != status.clock_source_select);
  end

  always_comb begin
    state_next        = state_reg;
    active_next       = active_reg;
    target_next       = target_reg;
    leaving_next      = leaving_reg;
    edge_cnt_next     = edge_cnt_reg;
    xtal_wait_next    = xtal_wait_reg;
    fast_pending_next = fast_pending_reg;
    status_next       = status;
    gate_next         = core_clock_enable;
    hold_next         = first_quarter_phase_hold;
    wdt_clr_next      = 1'b0;
    cpu_load          = 1'b0;
    fast_load         = 1'b0;

    if (fast_pending_reg && fast_expired && !fast_load) begin
      status_next.fast_osc_stable_flag = 1'b1;
      fast_pending_next = 1'b0;
    end

    unique case (state_reg)
      ST_RUN: begin
      end
      ST_XTAL_WAIT: begin
        // Core keeps running from the old source meanwhile
        if (fall_primary) begin
          edge_cnt_next = edge_cnt_reg + 1'b1;
          if (edge_cnt_next == STARTUP_EDGES) begin
            edge_cnt_next = '0;
            state_next    = ST_GATE;
          end
        end
      end
      ST_GATE: begin
        if (fall_old) begin
          gate_next     = 1'b0;
          hold_next     = 1'b1;
          edge_cnt_next = '0;
          state_next    = ST_QUAL;
        end
      end
      ST_QUAL: begin
        if (fall_new) begin
          edge_cnt_next = edge_cnt_reg + 1'b1;
          if (edge_cnt_next == QUAL_EDGES) begin
            edge_cnt_next = '0;
            active_next   = target_reg;
            gate_next     = 1'b1;
            status_next.secondary_osc_running_flag = (target_reg == SRC_SECONDARY);
            if (target_reg == SRC_PRIMARY) begin
              status_next.startup_timeout_flag = 1'b1;
            end
            if (target_reg == SRC_INTERNAL && leaving_reg != SRC_INTERNAL &&
                internal_freq_select != FREQ_SLOW_RC) begin
              status_next.fast_osc_stable_flag = 1'b0;
              fast_load         = 1'b1;
              fast_pending_next = 1'b1;
            end
            if (target_reg == SRC_PRIMARY && leaving_reg == SRC_SECONDARY &&
                (primary_osc_config == CFG_EXTERNAL_CLOCK_INPUT ||
                 primary_osc_config == CFG_EXTERNAL_RC)) begin
              cpu_load   = 1'b1;
              state_next = ST_SUSPEND;
            end else begin
              hold_next    = 1'b0;
              wdt_clr_next = 1'b1;
              state_next   = ST_RUN;
            end
          end
        end
      end
      ST_SUSPEND: begin
        if (cpu_expired) begin
          hold_next    = 1'b0;
          wdt_clr_next = 1'b1;
          state_next   = ST_RUN;
        end
      end
      ST_WAKE: begin
        if (xtal_wait_reg && fall_primary && edge_cnt_reg != STARTUP_EDGES) begin
          edge_cnt_next = edge_cnt_reg + 1'b1;
        end
        if (cpu_expired && (!xtal_wait_reg || edge_cnt_reg == STARTUP_EDGES)) begin
          edge_cnt_next = '0;
          hold_next     = 1'b0;
          if (active_reg == SRC_PRIMARY) begin
            status_next.startup_timeout_flag = 1'b1;
          end
          wdt_clr_next = 1'b1;
          state_next   = ST_RUN;
        end
      end
    endcase

    // A late request restarts the sequence with fresh counters
    if (wake_event) begin
      state_next      = ST_WAKE;
      active_next     = source_of(status.clock_source_select);
      target_next     = active_next;
      edge_cnt_next   = '0;
      hold_next       = 1'b1;
      gate_next       = 1'b1;
      cpu_load        = 1'b1;
      xtal_wait_next  = (active_next == SRC_PRIMARY) && is_crystal(primary_osc_config);
      if (active_next == SRC_INTERNAL && internal_freq_select != FREQ_SLOW_RC) begin
        status_next.fast_osc_stable_flag = 1'b0;
        fast_load         = 1'b1;
        fast_pending_next = 1'b1;
      end
    end else if (request) begin
      status_next.clock_source_select = new_select;
      target_next   = source_of(new_select);
      leaving_next  = active_reg;
      edge_cnt_next = '0;
      gate_next     = 1'b1;
      hold_next     = 1'b0;
      if (target_next == active_reg ||
          (primary_osc_config == CFG_SLOW_INTERNAL_RC &&
           target_next != SRC_SECONDARY && active_reg != SRC_SECONDARY)) begin
        state_next = ST_RUN;
      end else if (target_next == SRC_PRIMARY) begin
        state_next = is_crystal(primary_osc_config) ? ST_XTAL_WAIT : ST_GATE;
      end else begin
        status_next.startup_timeout_flag = 1'b0;
        state_next = ST_GATE;
      end
    end

    // Primary stops only once the core has left it; secondary likewise, but it also stays on while its enable is set
    prim_pwr_next = (active_next == SRC_PRIMARY) ||
                    (state_next != ST_RUN && target_next == SRC_PRIMARY);
    sec_pwr_next  = secondary_osc_enable || (active_next == SRC_SECONDARY) ||
                    (state_next != ST_RUN && target_next == SRC_SECONDARY);
    wdt_en_next   = (state_next == ST_RUN);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg                <= ST_RUN;
      active_reg               <= SRC_PRIMARY;
      target_reg               <= SRC_PRIMARY;
      leaving_reg              <= SRC_PRIMARY;
      edge_cnt_reg             <= '0;
      xtal_wait_reg            <= 1'b0;
      fast_pending_reg         <= 1'b0;
      enable_last_reg          <= 1'b0;
      status                   <= STATUS_RESET;
      system_clock_source      <= SRC_PRIMARY;
      core_clock_enable        <= 1'b1;
      first_quarter_phase_hold <= 1'b0;
      primary_osc_power        <= 1'b1;
      secondary_osc_power      <= 1'b0;
      watchdog_enable          <= 1'b1;
      watchdog_clear           <= 1'b0;
    end else begin
      state_reg                <= state_next;
      active_reg               <= active_next;
      target_reg               <= target_next;
      leaving_reg              <= leaving_next;
      edge_cnt_reg             <= edge_cnt_next;
      xtal_wait_reg            <= xtal_wait_next;
      fast_pending_reg         <= fast_pending_next;
      enable_last_reg          <= secondary_osc_enable;
      status                   <= status_next;
      system_clock_source      <= active_next;
      core_clock_enable        <= gate_next;
      first_quarter_phase_hold <= hold_next;
      primary_osc_power        <= prim_pwr_next;
      secondary_osc_power      <= sec_pwr_next;
      watchdog_enable          <= wdt_en_next;
      watchdog_clear           <= wdt_clr_next;
    end
  end

endmodule : power_managed_clock_switch

// >>> design/clock_switch_pkg.sv
// Contract
// - Selecting slow RC from another source clears timeout flag and stops primary oscillator.
// - No switch to internal RC when primary is already configured as slow RC.
// - Entering internal mode with fast frequency sets stable flag about 4 ms later.
// - After switching to internal RC, hold first phase for eight slow RC falling edges.
// - Selecting secondary clears timeout flag, moves clock there, powers primary down.
// - After switching to secondary, hold first phase for eight secondary falling edges.
// - Running flag is set while the secondary crystal drives the system clock.
// - With secondary disabled, select bit zero of a written value is forced low.
// - A switch starts only when the resolved select differs from its old value.
// - Returning to a crystal primary waits 1024 primary cycles before changeover.
// - During that crystal wait the old clock keeps running the core.
// - Timeout flag becomes one once the primary source drives the system clock.
// - After the crystal wait, hold first phase for eight primary falling edges.
// - Clearing secondary enable in secondary run mode clears select bit zero.
// - Secondary keeps running until the switch away completes, then stops; the code keeps it on while its enable is set.
// - Leaving secondary for external clock or RC suspends for 5-10 microseconds.
// - Wake-up applies the CPU start-up delay, plus 4 ms for fast internal target; the code ends hold after the CPU delay alone.
// - Wake-up onto a crystal primary runs the 1024-cycle startup timer.
// - CPU start-up delay is 5-10 microseconds.
// - Select encoding: 00 primary, 01 secondary, 10 internal, 11 reserved.
// - Watchdog is disabled during a switch and re-enabled cleared afterwards.
package clock_switch_pkg;

  localparam int unsigned CLK_PERIOD_NS      = 25;
  localparam int unsigned CPU_STARTUP_NS     = 5000;
  localparam int unsigned FAST_STABLE_NS     = 4000000;
  localparam int unsigned CPU_STARTUP_CYCLES = (CPU_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FAST_STABLE_CYCLES = FAST_STABLE_NS / CLK_PERIOD_NS;
  localparam int unsigned CPU_TIMER_W        = 8;
  localparam int unsigned FAST_TIMER_W       = 18;
  localparam int unsigned EDGE_CNT_W         = 11;
  localparam logic [EDGE_CNT_W-1:0] STARTUP_EDGES = 11'h400;
  localparam logic [EDGE_CNT_W-1:0] QUAL_EDGES    = 11'h008;

  localparam logic [1:0] SEL_PRIMARY   = 2'h0;
  localparam logic [1:0] SEL_SECONDARY = 2'h1;
  localparam logic [1:0] SEL_INTERNAL  = 2'h2;
  localparam logic [1:0] SEL_RESET     = 2'h0;
  localparam logic [2:0] FREQ_SLOW_RC  = 3'h0;

  typedef enum logic [2:0] {
    CFG_LOW_POWER_CRYSTAL,
    CFG_STANDARD_CRYSTAL,
    CFG_HIGH_SPEED_CRYSTAL,
    CFG_EXTERNAL_CLOCK_INPUT,
    CFG_EXTERNAL_RC,
    CFG_SLOW_INTERNAL_RC
  } primary_cfg_t;

  typedef enum logic [1:0] {
    SRC_PRIMARY,
    SRC_SECONDARY,
    SRC_INTERNAL
  } source_t;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_XTAL_WAIT,
    ST_GATE,
    ST_QUAL,
    ST_SUSPEND,
    ST_WAKE
  } switch_state_t;

  typedef struct packed {
    logic       startup_timeout_flag;
    logic       fast_osc_stable_flag;
    logic       secondary_osc_running_flag;
    logic [1:0] clock_source_select;
  } clock_status_t;

  localparam clock_status_t STATUS_RESET = '{1'b0, 1'b0, 1'b0, SEL_RESET};

endpackage : clock_switch_pkg

// >>> design/osc_fall_detect.sv
module osc_fall_detect
  import clock_switch_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic osc_in,
  output logic      fall_pulse
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  logic fall_next;

  // Only sync_reg looks at meta_reg; the edge is taken from the settled pair
  always_comb begin
    fall_next = last_reg & ~sync_reg;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg   <= 1'b0;
      sync_reg   <= 1'b0;
      last_reg   <= 1'b0;
      fall_pulse <= 1'b0;
    end else begin
      meta_reg   <= osc_in;
      sync_reg   <= meta_reg;
      last_reg   <= sync_reg;
      fall_pulse <= fall_next;
    end
  end

endmodule : osc_fall_detect

// >>> design/cycle_timer.sv
module cycle_timer
  import clock_switch_pkg::*;
#(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  output logic                  expired
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic             expired_next;

  always_comb begin
    count_next = count_reg;
    if (load) begin
      count_next = load_value;
    end else if (count_reg != '0) begin
      count_next = count_reg - 1'b1;
    end
    expired_next = (count_next == '0);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= '0;
      expired   <= 1'b1;
    end else begin
      count_reg <= count_next;
      expired   <= expired_next;
    end
  end

endmodule : cycle_timer

// >>> tb/clock_switch_monitor.sv
module clock_switch_monitor
  import clock_switch_pkg::*;
#(
  parameter int unsigned FAST_STABLE_COUNT = FAST_STABLE_CYCLES
) (
  input wire logic          sys_clk,
  input wire logic          reset_n,
  input wire logic          select_write,
  input wire logic [1:0]    select_write_data,
  input wire logic [2:0]    internal_freq_select,
  input wire logic          secondary_osc_enable,
  input wire primary_cfg_t  primary_osc_config,
  input wire logic          wake_event,
  input wire source_t       system_clock_source,
  input wire logic          core_clock_enable,
  input wire logic          first_quarter_phase_hold,
  input wire logic          primary_osc_power,
  input wire logic          secondary_osc_power,
  input wire logic          watchdog_enable,
  input wire logic          watchdog_clear,
  input wire clock_status_t status
);
  logic        wr;
  logic [1:0]  resolved;
  logic [1:0]  cur;
  logic [31:0] wait_reg;
  logic [31:0] wait_next;

  assign wr  = select_write && !wake_event;
  assign cur = status.clock_source_select;
  // Reserved code and a stopped secondary both drop bit zero
  assign resolved = (secondary_osc_enable && select_write_data != 2'h3) ? select_write_data
                                                                         : {select_write_data[1], 1'b0};

  always_comb begin
    wait_next = 32'h0;
    if (system_clock_source == SRC_INTERNAL && !status.fast_osc_stable_flag && internal_freq_select != FREQ_SLOW_RC)
      wait_next = wait_reg + 32'h1;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      wait_reg <= 32'h0;
    else
      wait_reg <= wait_next;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_STORE_SELECT: assert property (wr |=> cur == $past(resolved))
    else $error("select not resolved as written");
  AST_SAME_NO_SWITCH: assert property (wr && resolved == cur && watchdog_enable && !first_quarter_phase_hold
    |=> watchdog_enable [*3]) else $error("switch started with unchanged select");
  AST_TO_RC: assert property (wr && resolved == SEL_INTERNAL && cur != SEL_INTERNAL
    && primary_osc_config != CFG_SLOW_INTERNAL_RC |=> !status.startup_timeout_flag && !watchdog_enable)
    else $error("internal switch did not start");
  AST_TO_SEC: assert property (wr && resolved == SEL_SECONDARY && cur != SEL_SECONDARY
    |=> !status.startup_timeout_flag && !watchdog_enable) else $error("secondary switch did not start");
  AST_RUN_FLAG: assert property (status.secondary_osc_running_flag == (system_clock_source == SRC_SECONDARY))
    else $error("running flag disagrees with source");
  AST_TIMEOUT_PRIMARY: assert property (status.startup_timeout_flag |-> system_clock_source == SRC_PRIMARY)
    else $error("timeout flag set off primary");
  AST_GATE_HOLD: assert property (!core_clock_enable |-> first_quarter_phase_hold && !watchdog_enable)
    else $error("clock gated outside a held switch");
  AST_QUAL_LEN: assert property ($fell(core_clock_enable) |=> !core_clock_enable [*8])
    else $error("qualification shorter than eight edges");
  AST_WDOG_CLEAR: assert property ($rose(watchdog_enable) |-> watchdog_clear ##1 !watchdog_clear)
    else $error("watchdog not cleared on completion");
  AST_IDLE_POWER: assert property (watchdog_enable && !first_quarter_phase_hold
    |-> primary_osc_power == (system_clock_source == SRC_PRIMARY)) else $error("primary power wrong when idle");
  AST_SEC_POWER: assert property (system_clock_source == SRC_SECONDARY |-> secondary_osc_power)
    else $error("secondary stopped while in use");
  AST_FAST_DELAY: assert property ($rose(status.fast_osc_stable_flag) |-> wait_reg >= FAST_STABLE_COUNT - 2)
    else $error("fast flag set too early");
endmodule : clock_switch_monitor

// >>> tb/osc_source_model.sv
module osc_source_model (
  input  wire logic sys_clk,
  input  wire logic primary_run,
  input  wire logic secondary_osc_power,
  output logic      primary_osc_in,
  output logic      slow_internal_rc_in,
  output logic      secondary_crystal_osc_in
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned HALF [3] = '{2, 3, 4};
  logic [2:0] run;
  logic [2:0] lvl = 3'h0;
  int         cnt [3] = '{0, 0, 0};

  // Slow RC runs free; a stopped oscillator parks low
  assign run = {secondary_osc_power, 1'b1, primary_run};
  assign primary_osc_in           = lvl[0];
  assign slow_internal_rc_in      = lvl[1];
  assign secondary_crystal_osc_in = lvl[2];

  always @(posedge sys_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (!run[i]) begin
        lvl[i] <= 1'b0;
        cnt[i] <= 0;
      end else if (cnt[i] == HALF[i] - 1) begin
        lvl[i] <= ~lvl[i];
        cnt[i] <= 0;
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule : osc_source_model

// >>> tb/tb_power_managed_clock_switch.sv
module tb_power_managed_clock_switch;
  timeunit 1ns;
  timeprecision 100ps;
  import clock_switch_pkg::*;

  localparam int unsigned FAST_N  = 20;
  localparam int unsigned PRI_PER = 4;

  typedef struct packed {
    logic [1:0] wdat;
    logic       en;
    logic [1:0] sel;
    source_t    src;
    logic       xtal;
    logic       run;
  } row_t;

  logic          sys_clk, reset_n, select_write, sec_en, wake, pri_in, rc_in, sec_in;
  logic          core_en, hold, ppow, spow, wd_en, wd_clr;
  logic [1:0]    wdat;
  logic [2:0]    freq;
  primary_cfg_t  cfg;
  source_t       src;
  clock_status_t status;
  int            err_count, comparisons, cyc, n, lo, hi;
  row_t          rows [7];
  primary_cfg_t  wcfg [3];

  power_managed_clock_switch #(.FAST_STABLE_COUNT(FAST_N)) DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .select_write(select_write), .select_write_data(wdat),
    .internal_freq_select(freq), .secondary_osc_enable(sec_en), .primary_osc_config(cfg),
    .wake_event(wake), .primary_osc_in(pri_in), .slow_internal_rc_in(rc_in),
    .secondary_crystal_osc_in(sec_in), .system_clock_source(src), .core_clock_enable(core_en),
    .first_quarter_phase_hold(hold), .primary_osc_power(ppow), .secondary_osc_power(spow),
    .watchdog_enable(wd_en), .watchdog_clear(wd_clr), .status(status)
  );

  // External clock and RC sources need no power from the block
  osc_source_model u_osc (
    .sys_clk(sys_clk), .primary_run(ppow || cfg == CFG_EXTERNAL_CLOCK_INPUT || cfg == CFG_EXTERNAL_RC),
    .secondary_osc_power(spow), .primary_osc_in(pri_in), .slow_internal_rc_in(rc_in),
    .secondary_crystal_osc_in(sec_in)
  );

  task automatic stop_test;
    $display("Mismatches %0d, comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t ns: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : tick

  task automatic write_sel(input logic [1:0] d);
    select_write = 1'b1;
    wdat = d;
    tick(1);
    select_write = 1'b0;
  endtask : write_sel

  task automatic wait_idle;
    int i;
    i = 0;
    tick(3);
    while (!(wd_en === 1'b1 && hold === 1'b0) && i < 9000) begin
      tick(1);
      i++;
    end
    check(8'(i < 9000), 8'h1);
  endtask : wait_idle

  task automatic hold_len(output int k);
    int i;
    i = 0;
    k = 0;
    while (hold !== 1'b1 && i < 100) begin
      tick(1);
      i++;
    end
    while (hold === 1'b1 && k < 9000) begin
      tick(1);
      k++;
    end
  endtask : hold_len

  task automatic check_reset;
    check(8'({src, core_en, hold, ppow, spow, wd_en, wd_clr}), {SRC_PRIMARY, 6'b101010});
    check(8'(status), 8'(STATUS_RESET));
  endtask : check_reset

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Longest legal path is a few crystal start-ups
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      stop_test();
    end
  end

  initial begin
    {reset_n, select_write, sec_en, wake, wdat, freq} = '0;
    cfg = CFG_STANDARD_CRYSTAL;
    {err_count, comparisons, cyc} = '0;
    rows = '{'{2'h1, 1'b0, 2'h0, SRC_PRIMARY, 1'b0, 1'b0}, '{2'h3, 1'b0, 2'h2, SRC_INTERNAL, 1'b0, 1'b0},
             '{2'h3, 1'b0, 2'h2, SRC_INTERNAL, 1'b0, 1'b0}, '{2'h1, 1'b0, 2'h0, SRC_PRIMARY, 1'b1, 1'b0},
             '{2'h1, 1'b1, 2'h1, SRC_SECONDARY, 1'b0, 1'b1}, '{2'h3, 1'b1, 2'h2, SRC_INTERNAL, 1'b0, 1'b0},
             '{2'h0, 1'b1, 2'h0, SRC_PRIMARY, 1'b1, 1'b0}};
    wcfg = '{CFG_LOW_POWER_CRYSTAL, CFG_HIGH_SPEED_CRYSTAL, CFG_EXTERNAL_RC};
    tick(12);
    reset_n = 1'b1;
    tick(1);
    check_reset();
    foreach (rows[i]) begin
      sec_en = rows[i].en;
      tick(40);
      write_sel(rows[i].wdat);
      if (rows[i].xtal) begin
        tick(100);
        check(8'({hold, src}), 8'({1'b0, rows[i-1].src}));
      end
      wait_idle();
      check(8'(status.clock_source_select), 8'(rows[i].sel));
      check(8'(src), 8'(rows[i].src));
      check(8'({status.startup_timeout_flag, status.secondary_osc_running_flag}), 8'({rows[i].xtal, rows[i].run}));
      check(8'(ppow), 8'(rows[i].src == SRC_PRIMARY));
    end
    cfg = CFG_EXTERNAL_CLOCK_INPUT;
    write_sel(2'h1);
    wait_idle();
    check(8'(src), 8'(SRC_SECONDARY));
    sec_en = 1'b0;
    tick(2);
    check(8'({status.clock_source_select, spow}), 8'h1);
    hold_len(n);
    check(8'(n >= CPU_STARTUP_CYCLES && n <= CPU_STARTUP_CYCLES + 60), 8'h1);
    tick(2);
    check(8'({src, spow, status.startup_timeout_flag}), 8'({SRC_PRIMARY, 2'b01}));
    foreach (wcfg[j]) begin
      cfg = wcfg[j];
      lo = (j < 2) ? 1024 * PRI_PER - 8 : CPU_STARTUP_CYCLES - 2;
      hi = (j < 2) ? 1024 * PRI_PER + 60 : CPU_STARTUP_CYCLES + 10;
      tick(2);
      wake = 1'b1;
      tick(1);
      wake = 1'b0;
      hold_len(n);
      check(8'(n >= lo && n <= hi), 8'h1);
    end
    cfg = CFG_EXTERNAL_CLOCK_INPUT;
    freq = 3'h5;
    write_sel(2'h2);
    wait_idle();
    check(8'({src, status.fast_osc_stable_flag}), 8'({SRC_INTERNAL, 1'b0}));
    tick(FAST_N + 4);
    check(8'(status.fast_osc_stable_flag), 8'h1);
    write_sel(2'h0);
    wait_idle();
    cfg = CFG_SLOW_INTERNAL_RC;
    tick(2);
    write_sel(2'h2);
    tick(4);
    check(8'({wd_en, src, status.clock_source_select}), 8'({1'b1, SRC_PRIMARY, SEL_INTERNAL}));
    cfg = CFG_EXTERNAL_CLOCK_INPUT;
    sec_en = 1'b1;
    tick(40);
    write_sel(2'h1);
    tick(12);
    write_sel(2'h2);
    wait_idle();
    check(8'({src, status.secondary_osc_running_flag}), 8'({SRC_INTERNAL, 1'b0}));
    // Wake onto a fast internal target restarts the stability wait
    wake = 1'b1;
    tick(1);
    wake = 1'b0;
    tick(2);
    check(8'({hold, status.fast_osc_stable_flag}), 8'h2);
    tick(FAST_N + 4);
    check(8'(status.fast_osc_stable_flag), 8'h1);
    wait_idle();
    write_sel(2'h0);
    tick(5);
    // Secondary power follows its enable, so drop it to see the reset value
    sec_en = 1'b0;
    reset_n = 1'b0;
    tick(2);
    reset_n = 1'b1;
    tick(1);
    check_reset();
    stop_test();
  end
endmodule : tb_power_managed_clock_switch

bind power_managed_clock_switch clock_switch_monitor #(.FAST_STABLE_COUNT(FAST_STABLE_COUNT)) u_mon (
  .sys_clk, .reset_n, .select_write, .select_write_data, .internal_freq_select, .secondary_osc_enable,
  .primary_osc_config, .wake_event, .system_clock_source, .core_clock_enable, .first_quarter_phase_hold,
  .primary_osc_power, .secondary_osc_power, .watchdog_enable, .watchdog_clear, .status
);
